// File: rtl/iag_defs.vh
// Constants for the interrupt acceptance gating block
// What this block does
// R1 - Enable clear takes effect after its instruction
// R2 - Higher pending priority wins, lower one dropped
// R3 - Source flag clear behaves like enable clear
// R4 - Clears while masked never cause an exception
// R5 - Mask instructions block all interrupts, NMI included
// R6 - New mask value effective two states later
// R7 - No acceptance for three states after mask update
// R8 - Byte-count block move holds off all interrupts
// R9 - Word-count block move accepts at transfer breaks
// R10 - Interrupted word move returns to next instruction
// R11 - Pin select change may set external flag
// R12 - Software changes selection only while request disabled
// R13 - Flags may be set after reset; software clears
// R14 - Level mode: accept only above mask level
// R15 - Level-mode acceptance clears trace, loads level, NMI seven
// R16 - Write zero clears flag only after read one
`ifndef IAG_DEFS_VH
`define IAG_DEFS_VH

// ****************************************************
// Register map, byte offsets
// ****************************************************
`define IAG_ADR_CTRL 8'h00
`define IAG_ADR_PINSEL 8'h04
`define IAG_ADR_ENABLE 8'h08
`define IAG_ADR_STATUS 8'h0C
`define IAG_ADR_PRIO_EXT 8'h10
`define IAG_ADR_PRIO_PER 8'h14
`define IAG_ADR_LAST 8'h18

// ****************************************************
// Field positions in the control register
// ****************************************************
`define IAG_CTRL_MODE 0
`define IAG_CTRL_IBIT 8
`define IAG_CTRL_LVL_LO 9
`define IAG_CTRL_TBIT 12

// ****************************************************
// Timing in states (one state is one clock)
// ****************************************************
`define IAG_MASK_APPLY_STATES 2'h2
`define IAG_BLOCK_STATES 2'h3

// ****************************************************
// Reset values and codes
// ****************************************************
`define IAG_LEVEL_RST 3'h7
`define IAG_LEVEL_NMI 3'h7
`define IAG_SRC_NMI 5'h10
`define IAG_NUM_SRC 16

`endif

// File: rtl/iag_gate.v
// Interrupt acceptance gating between sources and the CPU core
`timescale 1ns/1ps
`include "iag_defs.vh"

module iag_gate
(
   input wire clk_sys_in, // 100 MHz system clock
   input wire rst_in, // Async reset, active high
   input wire wb_cyc_in, // Wishbone cycle
   input wire wb_stb_in, // Wishbone strobe
   input wire wb_we_in, // Wishbone write enable
   input wire [7:0] wb_adr_in, // Wishbone byte address
   input wire [3:0] wb_sel_in, // Wishbone byte selects
   input wire [31:0] wb_dat_in, // Wishbone write data
   output wire [31:0] wb_dat_out, // Wishbone read data
   output wire wb_ack_out, // Wishbone acknowledge
   input wire [7:0] ext_pin_a_in, // External irq pins, choice A
   input wire [7:0] ext_pin_b_in, // External irq pins, choice B
   input wire nmi_pin_in, // Non-maskable pin, rising edge
   input wire [7:0] periph_irq_in, // Peripheral requests, level
   input wire cpu_instr_done_in, // Pulse: instruction completes
   input wire cpu_mask_instr_in, // Pulse: mask instruction completes
   input wire cpu_new_ibit_in, // New I bit from mask instruction
   input wire [2:0] cpu_new_level_in, // New mask level from mask instruction
   input wire block_move_bytecount_in, // Byte-count move in progress
   input wire block_move_wordcount_in, // Word-count move in progress
   input wire block_move_break_in, // Pulse: break between move cycles
   input wire [23:0] cpu_next_pc_in, // Address of next instruction
   output wire irq_accept_out, // Pulse: interrupt accepted
   output wire [4:0] irq_source_out, // Accepted source, 16 is NMI
   output wire [23:0] return_pc_out, // PC to push on stack
   output wire [2:0] mask_level_out, // Current mask level
   output wire ibit_out, // Current I bit
   output wire trace_clear_out // Pulse: trace bit cleared
);

   // ****************************************************
   // Functions
   // ****************************************************
   function [7:0] wb_merge;
      input [7:0] old_v;
      input [7:0] new_v;
      input lane;
      begin
         wb_merge = lane ? new_v : old_v;
      end
   endfunction

   // ****************************************************
   // Registers
   // ****************************************************
   reg [7:0] pin_a_s1_q;
   reg [7:0] pin_a_s2_q;
   reg [7:0] pin_b_s1_q;
   reg [7:0] pin_b_s2_q;
   reg nmi_s1_q;
   reg nmi_s2_q;
   reg nmi_prev_q;
   reg nmi_pend_q;
   reg [7:0] prev_lvl_q;
   reg [7:0] flag_q;
   reg [7:0] seen_q;
   reg [7:0] pinsel_q;
   reg [7:0] enable_q;
   reg [23:0] prio_ext_q;
   reg [23:0] prio_per_q;
   reg mode_q;
   reg ibit_q;
   reg tbit_q;
   reg [2:0] level_q;
   reg [15:0] cand_q;
   reg [1:0] hold_cnt_q, apply_cnt_q;
   reg pend_ibit_q;
   reg [2:0] pend_level_q;
   reg wb_ack_q;
   reg [31:0] wb_dat_q;
   reg accept_q;
   reg trace_clear_q;
   reg [4:0] source_q;
   reg [23:0] return_pc_q;

   // ****************************************************
   // Synchronisers and external flags
   // ****************************************************
   always @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pin_a_s1_q <= 8'h00;
         pin_a_s2_q <= 8'h00;
         pin_b_s1_q <= 8'h00;
         pin_b_s2_q <= 8'h00;
         nmi_s1_q <= 1'b0;
         nmi_s2_q <= 1'b0;
      end
      else
      begin
         pin_a_s1_q <= ext_pin_a_in;
         pin_a_s2_q <= pin_a_s1_q;
         pin_b_s1_q <= ext_pin_b_in;
         pin_b_s2_q <= pin_b_s1_q;
         nmi_s1_q <= nmi_pin_in;
         nmi_s2_q <= nmi_s1_q;
      end
   end

   // Selection mux sits before the edge detector, so a select change alone can edge
   wire [7:0] sel_lvl_w = (pinsel_q & pin_b_s2_q) | (~pinsel_q & pin_a_s2_q); // see R11
   // Previous level resets low: a pin high out of reset sets its flag
   wire [7:0] rise_w = sel_lvl_w & ~prev_lvl_q; // see R13

   // ****************************************************
   // Bus decode
   // ****************************************************
   wire [7:0] adr_w = {wb_adr_in[7:2], 2'b00};
   wire wb_req_w = wb_cyc_in & wb_stb_in & ~wb_ack_q;
   wire wb_wr_w = wb_req_w & wb_we_in;
   wire wb_rd_w = wb_req_w & ~wb_we_in;
   // One write strobe per register except the read-only LAST register
   wire wr_ctrl_w = wb_wr_w & (adr_w == `IAG_ADR_CTRL);
   wire wr_pinsel_w = wb_wr_w & (adr_w == `IAG_ADR_PINSEL);
   wire wr_enable_w = wb_wr_w & (adr_w == `IAG_ADR_ENABLE);
   wire wr_prio_ext_w = wb_wr_w & (adr_w == `IAG_ADR_PRIO_EXT);
   wire wr_prio_per_w = wb_wr_w & (adr_w == `IAG_ADR_PRIO_PER);
   wire wr_status_w = wb_wr_w & wb_sel_in[0] & (adr_w == `IAG_ADR_STATUS);
   // Only flags seen as one are cleared by a zero
   wire [7:0] flag_clr_w = wr_status_w ? (~wb_dat_in[7:0] & seen_q) : 8'h00; // see R16

   reg [31:0] rd_data_w;
   always @*
   begin
      rd_data_w = 32'h00000000;
      if (adr_w == `IAG_ADR_CTRL)
      begin
         rd_data_w[`IAG_CTRL_MODE] = mode_q;
         rd_data_w[`IAG_CTRL_IBIT] = ibit_q;
         rd_data_w[`IAG_CTRL_LVL_LO +: 3] = level_q;
         rd_data_w[`IAG_CTRL_TBIT] = tbit_q;
      end
      else if (adr_w == `IAG_ADR_PINSEL)
         rd_data_w[7:0] = pinsel_q;
      else if (adr_w == `IAG_ADR_ENABLE)
         rd_data_w[7:0] = enable_q;
      else if (adr_w == `IAG_ADR_STATUS)
         rd_data_w[7:0] = flag_q;
      else if (adr_w == `IAG_ADR_PRIO_EXT)
         rd_data_w[23:0] = prio_ext_q;
      else if (adr_w == `IAG_ADR_PRIO_PER)
         rd_data_w[23:0] = prio_per_q;
      else if (adr_w == `IAG_ADR_LAST)
         rd_data_w[4:0] = source_q;
   end

   // ****************************************************
   // Priority selection
   // ****************************************************
   wire [15:0] req_w = {periph_irq_in, flag_q & enable_q};
   reg [15:0] elig_w;
   reg best_vld_w;
   reg [3:0] best_idx_w;
   reg [2:0] best_prio_w;
   reg [2:0] prio_w;
   integer i;
   always @*
   begin
      elig_w = 16'h0000;
      best_vld_w = 1'b0;
      best_idx_w = 4'h0;
      best_prio_w = 3'h0;
      prio_w = 3'h0;
      for (i = 0; i < `IAG_NUM_SRC; i = i + 1)
      begin
         // Split select keeps every part-select inside its register
         if (i < 8)
            prio_w = prio_ext_q[3*i +: 3];
         else
            prio_w = prio_per_q[3*(i-8) +: 3];
         // Masked sources never enter the candidate set
         if (mode_q)
            elig_w[i] = (prio_w > level_q); // see R14 see R4
         else
            elig_w[i] = ~ibit_q; // see R4
         // Lowest index wins among equals; strictly higher priority overrides
         if (elig_w[i] && (req_w[i] || cand_q[i]) && (!best_vld_w || prio_w > best_prio_w))
         begin
            best_vld_w = 1'b1;
            best_idx_w = i[3:0];
            best_prio_w = prio_w;
         end
      end
   end

   // ****************************************************
   // Acceptance windows
   // ****************************************************
   // Mask instruction's own boundary and the following states take nothing
   wire blocked_w = cpu_mask_instr_in | (hold_cnt_q != 2'h0); // see R5 see R7
   // Byte move completes before any boundary opens; word move opens at breaks
   wire point_w = (cpu_instr_done_in & ~block_move_bytecount_in) // see R8
                | (block_move_wordcount_in & block_move_break_in); // see R9
   wire take_nmi_w = point_w & ~blocked_w & nmi_pend_q;
   wire take_irq_w = point_w & ~blocked_w & ~nmi_pend_q & best_vld_w;

   // ****************************************************
   // Bus slave registers
   // ****************************************************
   always @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h00000000;
         mode_q <= 1'b0;
         pinsel_q <= 8'h00;
         enable_q <= 8'h00;
         prio_ext_q <= 24'h000000;
         prio_per_q <= 24'h000000;
      end
      else
      begin
         // One-cycle ack, unmapped reads zero, unmapped writes dropped
         wb_ack_q <= wb_req_w;
         if (wb_rd_w)
            wb_dat_q <= rd_data_w;
         if (wr_ctrl_w && wb_sel_in[0])
            mode_q <= wb_dat_in[`IAG_CTRL_MODE];
         if (wr_pinsel_w)
            pinsel_q <= wb_merge(pinsel_q, wb_dat_in[7:0], wb_sel_in[0]);
         if (wr_enable_w)
            enable_q <= wb_merge(enable_q, wb_dat_in[7:0], wb_sel_in[0]);
         if (wr_prio_ext_w)
            prio_ext_q <= {wb_merge(prio_ext_q[23:16], wb_dat_in[23:16], wb_sel_in[2]),
                           wb_merge(prio_ext_q[15:8], wb_dat_in[15:8], wb_sel_in[1]),
                           wb_merge(prio_ext_q[7:0], wb_dat_in[7:0], wb_sel_in[0])};
         if (wr_prio_per_w)
            prio_per_q <= {wb_merge(prio_per_q[23:16], wb_dat_in[23:16], wb_sel_in[2]),
                           wb_merge(prio_per_q[15:8], wb_dat_in[15:8], wb_sel_in[1]),
                           wb_merge(prio_per_q[7:0], wb_dat_in[7:0], wb_sel_in[0])};
      end
   end

   // ****************************************************
   // Main state
   // ****************************************************
   always @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         prev_lvl_q <= 8'h00;
         flag_q <= 8'h00;
         seen_q <= 8'h00;
         ibit_q <= 1'b1;
         tbit_q <= 1'b0;
         level_q <= `IAG_LEVEL_RST;
         nmi_prev_q <= 1'b0;
         nmi_pend_q <= 1'b0;
         cand_q <= 16'h0000;
         hold_cnt_q <= 2'h0;
         apply_cnt_q <= 2'h0;
         pend_ibit_q <= 1'b0;
         pend_level_q <= 3'h0;
         accept_q <= 1'b0;
         trace_clear_q <= 1'b0;
         source_q <= 5'h00;
         return_pc_q <= 24'h000000;
      end
      else
      begin
         // External flags: a new edge wins over a clear in the same cycle
         prev_lvl_q <= sel_lvl_w;
         flag_q <= (flag_q & ~flag_clr_w) | rise_w; // see R11 see R13
         if (wb_rd_w && adr_w == `IAG_ADR_STATUS)
            seen_q <= flag_q; // see R16
         else
            seen_q <= seen_q & ~flag_clr_w;

         // NMI edge latch
         nmi_prev_q <= nmi_s2_q;
         if (nmi_s2_q && !nmi_prev_q)
            nmi_pend_q <= 1'b1;
         else if (take_nmi_w)
            nmi_pend_q <= 1'b0;

         // Candidates caught during the instruction survive a late clear
         if (point_w)
            cand_q <= 16'h0000; // see R2
         else
            cand_q <= cand_q | (req_w & elig_w); // see R1 see R3

         // Mask instruction: block window and delayed mask update
         if (cpu_mask_instr_in)
         begin
            hold_cnt_q <= `IAG_BLOCK_STATES; // see R7
            apply_cnt_q <= `IAG_MASK_APPLY_STATES; // see R6
            pend_ibit_q <= cpu_new_ibit_in;
            pend_level_q <= cpu_new_level_in;
         end
         else
         begin
            if (hold_cnt_q != 2'h0)
               hold_cnt_q <= hold_cnt_q - 2'h1;
            if (apply_cnt_q != 2'h0)
               apply_cnt_q <= apply_cnt_q - 2'h1;
         end
         // Hold outlasts the apply delay, so no acceptance competes here
         if (apply_cnt_q == 2'h1 && !cpu_mask_instr_in)
         begin
            ibit_q <= pend_ibit_q; // see R6
            level_q <= pend_level_q;
         end

         // Acceptance
         accept_q <= take_nmi_w | take_irq_w;
         trace_clear_q <= (take_nmi_w | take_irq_w) & mode_q;
         if (take_nmi_w || take_irq_w)
         begin
            source_q <= take_nmi_w ? `IAG_SRC_NMI : {1'b0, best_idx_w}; // see R2
            return_pc_q <= cpu_next_pc_in; // see R10
            if (mode_q)
            begin
               tbit_q <= 1'b0; // see R15
               level_q <= take_nmi_w ? `IAG_LEVEL_NMI : best_prio_w; // see R15
            end
            else
               ibit_q <= 1'b1;
         end
         else if (wr_ctrl_w && wb_sel_in[1])
            tbit_q <= wb_dat_in[`IAG_CTRL_TBIT];
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign wb_dat_out = wb_dat_q;
   assign wb_ack_out = wb_ack_q;
   assign irq_accept_out = accept_q;
   assign irq_source_out = source_q;
   assign return_pc_out = return_pc_q;
   assign mask_level_out = level_q;
   assign ibit_out = ibit_q;
   assign trace_clear_out = trace_clear_q;

endmodule // iag_gate

// File: verification/iag_cpu_model.sv
// CPU core model issuing instruction boundaries and mask updates
`timescale 1ns/1ps
module iag_cpu_model
(
   input wire clk_sys_in, // System clock
   input wire rst_in, // Async reset
   input wire step_in, // Finish one instruction
   input wire mask_in, // That instruction alters masks
   input wire [2:0] level_in, // Level it loads
   output reg done_out, // Boundary pulse
   output reg mask_out, // Mask instruction pulse
   output reg ibit_out, // New I bit
   output reg [2:0] level_out, // New level
   output reg [23:0] pc_out // Address of next instruction
);
always @(posedge clk_sys_in or posedge rst_in)
begin
   if (rst_in)
   begin
      done_out <= 1'b0;
      mask_out <= 1'b0;
      ibit_out <= 1'b0;
      level_out <= 3'h0;
      pc_out <= 24'h000100;
   end
   else
   begin
      done_out <= step_in;
      mask_out <= step_in & mask_in;
      // Mask values are junk outside a mask pulse
      ibit_out <= (step_in & mask_in) ? 1'b0 : ~ibit_out;
      level_out <= (step_in & mask_in) ? level_in : ~level_out;
      if (done_out)
         pc_out <= pc_out + 24'h000002;
   end
end
endmodule // iag_cpu_model

// File: verification/iag_monitor.sv
// Assertion checker for the interrupt acceptance gating block
`timescale 1ns/1ps
module iag_monitor
(
   input wire clk_sys_in, // System clock
   input wire rst_in, // Async reset
   input wire wb_cyc_in, // Cycle
   input wire wb_stb_in, // Strobe
   input wire wb_ack_out, // Acknowledge
   input wire cpu_instr_done_in, // Boundary
   input wire cpu_mask_instr_in, // Mask instruction
   input wire [2:0] cpu_new_level_in, // New level
   input wire block_move_bytecount_in, // Byte move
   input wire block_move_wordcount_in, // Word move
   input wire block_move_break_in, // Move break
   input wire [23:0] cpu_next_pc_in, // Next PC
   input wire irq_accept_out, // Accept pulse
   input wire [4:0] irq_source_out, // Accepted source
   input wire [23:0] return_pc_out, // Return PC
   input wire [2:0] mask_level_out, // Mask level
   input wire trace_clear_out // Trace clear pulse
);
default clocking cb @(posedge clk_sys_in); endclocking
default disable iff (rst_in);
a_ack_one_shot: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
a_ack_answer: assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out) else $error("no ack");
a_mask_block: assert property (cpu_mask_instr_in |=> !irq_accept_out [*4])
   else $error("accept inside mask window");
a_mask_apply: assert property (cpu_mask_instr_in |-> ##2 $stable(mask_level_out)
   ##1 mask_level_out == $past(cpu_new_level_in, 3)) else $error("mask level applied at wrong time");
a_byte_hold: assert property (block_move_bytecount_in |=> !irq_accept_out)
   else $error("accept during byte move");
a_accept_cause: assert property (irq_accept_out |-> $past((cpu_instr_done_in && !block_move_bytecount_in)
   || (block_move_wordcount_in && block_move_break_in))) else $error("accept without boundary");
a_return_pc: assert property (irq_accept_out |-> return_pc_out == $past(cpu_next_pc_in))
   else $error("wrong return pc");
a_trace_pair: assert property (trace_clear_out |-> irq_accept_out) else $error("trace clear alone");
a_nmi_level: assert property ((trace_clear_out && irq_source_out == 5'h10) |-> mask_level_out == 3'h7)
   else $error("nmi level not seven");
a_level_raise: assert property ((trace_clear_out && irq_source_out != 5'h10)
   |-> mask_level_out > $past(mask_level_out)) else $error("accepted at or below level");
endmodule // iag_monitor
bind iag_gate iag_monitor u_mon (.clk_sys_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .cpu_instr_done_in,
   .cpu_mask_instr_in, .cpu_new_level_in, .block_move_bytecount_in, .block_move_wordcount_in, .block_move_break_in,
   .cpu_next_pc_in, .irq_accept_out, .irq_source_out, .return_pc_out, .mask_level_out, .trace_clear_out);

// File: verification/tb_top.sv
// Self-checking bench for the interrupt acceptance gating block
`timescale 1ns/1ps
module tb_top;
reg clk_sys_in = 1'b0;
reg rst_in = 1'b1;
reg cyc = 1'b0;
reg we = 1'b0;
reg [7:0] adr = 8'h00;
reg [31:0] wdat = 32'h0;
reg [7:0] pin_a = 8'h01;
reg [7:0] pin_b = 8'h04;
reg nmi = 1'b0;
reg [7:0] per = 8'h00;
reg bmb = 1'b0;
reg bmw = 1'b0;
reg brk = 1'b0;
reg step = 1'b0;
reg msk = 1'b0;
reg [2:0] lvl = 3'h0;
reg [31:0] q;
integer errors;
integer n_tests;
wire [31:0] rdat;
wire ack;
wire done;
wire mpulse;
wire nibit;
wire [2:0] nlvl;
wire [23:0] pc;
wire irq_accept_out;
wire [4:0] irq_source_out;
wire [23:0] return_pc_out;
wire [2:0] mask_level_out;
wire ibit;
initial forever #5 clk_sys_in = ~clk_sys_in;
iag_cpu_model cpu (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .step_in(step), .mask_in(msk), .level_in(lvl),
   .done_out(done), .mask_out(mpulse), .ibit_out(nibit), .level_out(nlvl), .pc_out(pc));
iag_gate dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
   .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
   .ext_pin_a_in(pin_a), .ext_pin_b_in(pin_b), .nmi_pin_in(nmi), .periph_irq_in(per),
   .cpu_instr_done_in(done), .cpu_mask_instr_in(mpulse), .cpu_new_ibit_in(nibit), .cpu_new_level_in(nlvl),
   .block_move_bytecount_in(bmb), .block_move_wordcount_in(bmw), .block_move_break_in(brk),
   .cpu_next_pc_in(pc), .irq_accept_out(irq_accept_out), .irq_source_out(irq_source_out),
   .return_pc_out(return_pc_out), .mask_level_out(mask_level_out), .ibit_out(ibit), .trace_clear_out());
// ****************************************************
// Tasks
// ****************************************************
task end_sim;
begin
   $display("Comparisons %0d, mismatches %0d", n_tests, errors);
   if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
   else
      $display("[ FAIL ]");
   $finish;
end
endtask
task chk(input [31:0] got, input [31:0] exp);
begin
   n_tests = n_tests + 1;
   if (got !== exp)
   begin
      errors = errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
   end
end
endtask
// Request held up to the rising edge that samples ack; data taken there
task wb(input w, input [7:0] a, input [31:0] d);
   integer i;
begin
   @(posedge clk_sys_in);
   cyc <= 1'b1;
   we <= w;
   adr <= a;
   wdat <= d;
   i = 0;
   @(posedge clk_sys_in);
   while (ack !== 1'b1 && i < 20)
   begin
      @(posedge clk_sys_in);
      i = i + 1;
   end
   if (ack !== 1'b1)
   begin
      errors = errors + 1;
      $display("Error at %0t: bus timeout", $time);
      end_sim;
   end
   q = rdat;
   cyc <= 1'b0;
   we <= 1'b0;
end
endtask
task rd(input [7:0] a, input [31:0] exp);
begin
   wb(1'b0, a, 32'h0);
   chk(q, exp);
end
endtask
task stp(input m, input [2:0] l);
begin
   @(posedge clk_sys_in);
   step <= 1'b1;
   msk <= m;
   lvl <= l;
   @(posedge clk_sys_in);
   step <= 1'b0;
end
endtask
task setmask(input [2:0] l);
begin
   stp(1'b1, l);
   repeat (4) @(posedge clk_sys_in);
end
endtask
task acc(input hit, input [4:0] src);
   integer i;
   reg seen;
begin
   seen = 1'b0;
   for (i = 0; i < 6; i = i + 1)
   begin
      @(posedge clk_sys_in);
      if (irq_accept_out === 1'b1)
      begin
         seen = 1'b1;
         chk({27'h0, irq_source_out}, {27'h0, src});
      end
   end
   chk({31'h0, seen}, {31'h0, hit});
end
endtask
task pulse(input [7:0] p);
begin
   @(posedge clk_sys_in);
   per <= p;
   @(posedge clk_sys_in);
   per <= 8'h00;
end
endtask
// ****************************************************
// Main sequence
// ****************************************************
initial
begin
   errors = 0;
   n_tests = 0;
   repeat (16) @(posedge clk_sys_in);
   rst_in <= 1'b0;
   repeat (4) @(posedge clk_sys_in);
   rd(8'h00, 32'h00000F00);
   rd(8'h1C, 32'h0);
   rd(8'h0C, 32'h01);
   wb(1'b1, 8'h0C, 32'h0);
   rd(8'h0C, 32'h0);
   pin_a <= 8'h03;
   repeat (5) @(posedge clk_sys_in);
   wb(1'b1, 8'h0C, 32'h0);
   rd(8'h0C, 32'h02);
   wb(1'b1, 8'h0C, 32'hFF);
   rd(8'h0C, 32'h02);
   wb(1'b1, 8'h0C, 32'h0);
   rd(8'h0C, 32'h0);
   wb(1'b1, 8'h04, 32'h04);
   rd(8'h0C, 32'h04);
   wb(1'b1, 8'h0C, 32'h0);
   wb(1'b1, 8'h00, 32'h00001001);
   rd(8'h00, 32'h00001F01);
   wb(1'b1, 8'h14, 32'h00030140);
   setmask(3'h0);
   chk({29'h0, mask_level_out}, 32'h0);
   chk({31'h0, ibit}, 32'h0);
   pulse(8'h04);
   stp(1'b0, 3'h0);
   acc(1'b1, 5'h0A);
   chk({29'h0, mask_level_out}, 32'h5);
   rd(8'h00, 32'h00000A01);
   setmask(3'h0);
   pulse(8'h24);
   stp(1'b0, 3'h0);
   acc(1'b1, 5'h0D);
   setmask(3'h0);
   stp(1'b0, 3'h0);
   acc(1'b0, 5'h0);
   setmask(3'h7);
   pulse(8'h04);
   setmask(3'h0);
   stp(1'b0, 3'h0);
   acc(1'b0, 5'h0);
   bmb <= 1'b1;
   nmi <= 1'b1;
   repeat (3) @(posedge clk_sys_in);
   stp(1'b0, 3'h0);
   acc(1'b0, 5'h0);
   bmb <= 1'b0;
   stp(1'b0, 3'h0);
   acc(1'b1, 5'h10);
   chk({29'h0, mask_level_out}, 32'h7);
   nmi <= 1'b0;
   repeat (3) @(posedge clk_sys_in);
   nmi <= 1'b1;
   stp(1'b1, 3'h0);
   stp(1'b0, 3'h0);
   acc(1'b0, 5'h0);
   stp(1'b0, 3'h0);
   acc(1'b1, 5'h10);
   setmask(3'h0);
   per <= 8'h04;
   bmw <= 1'b1;
   @(posedge clk_sys_in);
   brk <= 1'b1;
   @(posedge clk_sys_in);
   brk <= 1'b0;
   acc(1'b1, 5'h0A);
   chk({8'h0, return_pc_out}, {8'h0, pc});
   per <= 8'h00;
   bmw <= 1'b0;
   rd(8'h18, 32'h0A);
   end_sim;
end
endmodule // tb_top
